// ==== logic/dts_defs.svh ====
// Constants for the track reformat, release and sense request command block.
// Assumes inclusion by bare name from design and bench files.
`ifndef DTS_DEFS_SVH
`define DTS_DEFS_SVH
`define DTS_OP_REFORMAT 8'hED
`define DTS_OP_RELEASE 8'h17
`define DTS_OP_SENSE 8'h03
`define DTS_ST_GOOD 8'h00
`define DTS_ST_CHECK 8'h02
`define DTS_SENSE_MIN 5'h04
`define DTS_SENSE_MAX 5'h16
`define DTS_ADD_LEN 8'h0E
`define DTS_ERR_CLASS 3'h7
`define DTS_ERR_CODE 4'h0
`define DTS_KEY_NONE 4'h0
`define DTS_KEY_UA 4'h6
`define DTS_ASC_NONE 8'h00
`define DTS_ASC_RESET 8'h29
`define DTS_SB_HEAD 5'h00
`define DTS_SB_KEY 5'h02
`define DTS_SB_INFO0 5'h03
`define DTS_SB_INFO1 5'h04
`define DTS_SB_INFO2 5'h05
`define DTS_SB_INFO3 5'h06
`define DTS_SB_ADDLEN 5'h07
`define DTS_SB_ASC 5'h0C
`define DTS_SB_DEV0 5'h12
`define DTS_SB_DEV1 5'h13
`define DTS_SB_DEV2 5'h14
`define DTS_SB_DEV3 5'h15
`define DTS_REG_CTRL 8'h00
`define DTS_REG_IRQ_STAT 8'h04
`define DTS_REG_IRQ_MASK 8'h08
`define DTS_REG_STATE 8'h0C
`define DTS_REG_SENSE_MAP 8'h10
`define DTS_REG_RESV_MAP 8'h14
`define DTS_CTRL_SINGLE 0
`define DTS_EV_FMT 0
`define DTS_EV_REL 1
`define DTS_EV_SENSE 2
`define DTS_EV_CC 3
`define DTS_NUM_EV 4
`define DTS_HS_BIT 64
`define DTS_TP_BIT 68
`endif

// ==== logic/dts_pkg.sv ====
// Types shared by the command block.
// Assumes dts_defs.svh carries every numeric constant.
package dts_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_FORMAT, ST_SEND} dts_state_t;
endpackage

// ==== logic/dts_cmd_core.sv ====
// Command handling for track reformat, logical unit release and sense request.
// Assumes commands, check conditions and reservations come from logic on clk_sys.
`timescale 1ns/1ps
`include "dts_defs.svh"

// Summary of operation
// - Reformat command rewrites track chosen by cylinder bytes 2-3 and head byte 4.
// - Header flag clear: default header written, supplied header bytes ignored.
// - Header flag set: supplied address and flag bytes written to the track.
// - Release with no matching reservation still answers GOOD, others untouched.
// - Third-party release only frees a third-party reservation for that device.
// - Sense request always answers in the extended format.
// - Sense held until fetched or owner sends another command to that unit.
// - Stored sense cleared once its transfer completes without a fatal error.
// - Single-initiator mode treats every sense request as from the owner.
// - Allocation length zero transfers exactly four bytes.
// - Transfer length is the lesser of allocation and 22 bytes.
// - Only a fatal error of the request itself gives CHECK CONDITION.
// - Sense request runs even when another initiator holds the reservation.
// - Byte 0 carries valid, class 7, code 0; byte 1 is zero.
// - Byte 2 holds only the sense key; bytes 3-6 information, MSB first.
// - Byte 7 is 14; byte 12 code; bytes 18-21 device errors; rest zero.
// - Valid flag set only when information bytes are meaningful.
// - Sense keys 0, 3, 5, 6 used; unit attention after reset.
module dts_cmd_core #(
	parameter int NUM_LUN = 8
)(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic cmd_valid,
	input wire logic [2:0] cmd_init,
	input wire logic [79:0] cmd_cdb,
	output logic cmd_ready,
	input wire logic cc_post,
	input wire logic [2:0] cc_lun,
	input wire logic [2:0] cc_init,
	input wire logic [3:0] cc_key,
	input wire logic [7:0] cc_asc,
	input wire logic [31:0] cc_info,
	input wire logic cc_info_ok,
	input wire logic [31:0] cc_dev_err,
	input wire logic resv_set,
	input wire logic [2:0] resv_lun,
	input wire logic [2:0] resv_init,
	input wire logic resv_tp,
	input wire logic [2:0] resv_tp_id,
	input wire logic fmt_done,
	input wire logic rs_fatal,
	input wire logic sense_ready,
	output logic fmt_start,
	output logic [15:0] fmt_cyl,
	output logic [7:0] fmt_head,
	output logic [15:0] fmt_hdr_lba,
	output logic [7:0] fmt_hdr_flag,
	output logic fmt_use_hdr,
	output logic sense_valid,
	output logic [7:0] sense_byte,
	output logic sense_last,
	output logic status_valid,
	output logic [7:0] status_code,
	output logic irq
);
	dts_pkg::dts_state_t state;
	logic single_init;
	logic [`DTS_NUM_EV-1:0] irq_stat, irq_mask, ev;
	// Sense store, one entry per unit
	logic sv [NUM_LUN];
	logic sany [NUM_LUN];
	logic [2:0] stag [NUM_LUN];
	logic [3:0] skey [NUM_LUN];
	logic [7:0] sasc [NUM_LUN];
	logic [31:0] sinfo [NUM_LUN];
	logic sinfo_ok [NUM_LUN];
	logic [31:0] sdev [NUM_LUN];
	// Reservation table
	logic ract [NUM_LUN];
	logic [2:0] rown [NUM_LUN];
	logic rtp [NUM_LUN];
	logic [2:0] rtpid [NUM_LUN];
	// Snapshot of the sense being sent
	logic [3:0] snap_key;
	logic [7:0] snap_asc;
	logic [31:0] snap_info;
	logic snap_ok;
	logic [31:0] snap_dev;
	logic snap_hit;
	logic [2:0] snap_lun;
	logic [4:0] idx, xfer_len, sel;
	logic [7:0] mux_byte;
	logic [7:0] op, alloc;
	logic [2:0] lun;
	logic take, owner, rs_hit, clr_other, rel_hit, accept, rs_end;
	logic [NUM_LUN-1:0] sense_map, resv_map;

	assign op = cmd_cdb[79:72];
	assign lun = cmd_cdb[71:69];
	assign alloc = cmd_cdb[47:40];
	assign take = clk_en && cmd_valid && state == dts_pkg::ST_IDLE;
	assign owner = sv[lun] && (sany[lun] || stag[lun] == cmd_init);
	assign rs_hit = sv[lun] && (single_init || sany[lun] || stag[lun] == cmd_init);
	assign clr_other = take && op != `DTS_OP_SENSE && owner;
	assign accept = state == dts_pkg::ST_SEND && sense_valid && sense_ready;
	assign rs_end = accept && sense_last;
	// Both the owner and the target device must match for a third-party release
	assign rel_hit = ract[lun] && rown[lun] == cmd_init
		&& (cmd_cdb[`DTS_TP_BIT] ? (rtp[lun] && rtpid[lun] == cmd_cdb[67:65]) : !rtp[lun]);

	always_comb
	begin
		for (int i = 0; i < NUM_LUN; i++)
		begin
			sense_map[i] = sv[i];
			resv_map[i] = ract[i];
		end
	end

	// Store is tagged so the keep/clear decision is made as each command arrives
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			for (int i = 0; i < NUM_LUN; i++)
			begin
				sv[i] <= 1'b1;
				sany[i] <= 1'b1;
				stag[i] <= 3'h0;
				skey[i] <= `DTS_KEY_UA;
				sasc[i] <= `DTS_ASC_RESET;
				sinfo[i] <= 32'h0;
				sinfo_ok[i] <= 1'b0;
				sdev[i] <= 32'h0;
			end
		end
		else if (clk_en)
		begin
			for (int i = 0; i < NUM_LUN; i++)
			begin
				if ((clr_other && lun == i) || (rs_end && snap_hit && !rs_fatal && snap_lun == i))
					sv[i] <= 1'b0;
				// A new check condition wins over a clear in the same cycle
				if (cc_post && cc_lun == i)
				begin
					sv[i] <= 1'b1;
					sany[i] <= 1'b0;
					stag[i] <= cc_init;
					skey[i] <= cc_key;
					sasc[i] <= cc_asc;
					sinfo[i] <= cc_info;
					sinfo_ok[i] <= cc_info_ok;
					sdev[i] <= cc_dev_err;
				end
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			for (int i = 0; i < NUM_LUN; i++)
			begin
				ract[i] <= 1'b0;
				rown[i] <= 3'h0;
				rtp[i] <= 1'b0;
				rtpid[i] <= 3'h0;
			end
		end
		else if (clk_en)
		begin
			for (int i = 0; i < NUM_LUN; i++)
			begin
				// No match leaves the table alone; status is GOOD either way
				if (take && op == `DTS_OP_RELEASE && rel_hit && lun == i)
					ract[i] <= 1'b0;
				if (resv_set && resv_lun == i)
				begin
					ract[i] <= 1'b1;
					rown[i] <= resv_init;
					rtp[i] <= resv_tp;
					rtpid[i] <= resv_tp_id;
				end
			end
		end
	end

	// Snapshot taken at the request; reservations are not consulted
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			snap_key <= `DTS_KEY_NONE;
			snap_asc <= `DTS_ASC_NONE;
			snap_info <= 32'h0;
			snap_ok <= 1'b0;
			snap_dev <= 32'h0;
			snap_hit <= 1'b0;
			snap_lun <= 3'h0;
			xfer_len <= `DTS_SENSE_MIN;
		end
		else if (clk_en && take && op == `DTS_OP_SENSE)
		begin
			snap_hit <= rs_hit;
			snap_lun <= lun;
			snap_key <= rs_hit ? skey[lun] : `DTS_KEY_NONE;
			snap_asc <= rs_hit ? sasc[lun] : `DTS_ASC_NONE;
			snap_info <= rs_hit ? sinfo[lun] : 32'h0;
			snap_ok <= rs_hit && sinfo_ok[lun];
			snap_dev <= rs_hit ? sdev[lun] : 32'h0;
			if (alloc == 8'h00)
				xfer_len <= `DTS_SENSE_MIN;
			else if (alloc > {3'h0, `DTS_SENSE_MAX})
				xfer_len <= `DTS_SENSE_MAX;
			else
				xfer_len <= alloc[4:0];
		end
	end

	// Extended layout is the only one produced
	assign sel = sense_valid ? idx + 5'h01 : idx;
	always_comb
	begin
		case (sel)
			`DTS_SB_HEAD: mux_byte = {snap_ok, `DTS_ERR_CLASS, `DTS_ERR_CODE};
			`DTS_SB_KEY: mux_byte = {4'h0, snap_key};
			`DTS_SB_INFO0: mux_byte = snap_info[31:24];
			`DTS_SB_INFO1: mux_byte = snap_info[23:16];
			`DTS_SB_INFO2: mux_byte = snap_info[15:8];
			`DTS_SB_INFO3: mux_byte = snap_info[7:0];
			`DTS_SB_ADDLEN: mux_byte = `DTS_ADD_LEN;
			`DTS_SB_ASC: mux_byte = snap_asc;
			`DTS_SB_DEV0: mux_byte = snap_dev[31:24];
			`DTS_SB_DEV1: mux_byte = snap_dev[23:16];
			`DTS_SB_DEV2: mux_byte = snap_dev[15:8];
			`DTS_SB_DEV3: mux_byte = snap_dev[7:0];
			default: mux_byte = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			state <= dts_pkg::ST_IDLE;
			cmd_ready <= 1'b0;
			idx <= 5'h00;
			sense_valid <= 1'b0;
			sense_byte <= 8'h00;
			sense_last <= 1'b0;
			status_valid <= 1'b0;
			status_code <= `DTS_ST_GOOD;
			fmt_start <= 1'b0;
			fmt_cyl <= 16'h0;
			fmt_head <= 8'h00;
			fmt_hdr_lba <= 16'h0;
			fmt_hdr_flag <= 8'h00;
			fmt_use_hdr <= 1'b0;
		end
		else if (clk_en)
		begin
			status_valid <= 1'b0;
			fmt_start <= 1'b0;
			cmd_ready <= 1'b0;
			case (state)
				dts_pkg::ST_IDLE:
				begin
					cmd_ready <= !cmd_valid;
					if (cmd_valid && op == `DTS_OP_REFORMAT)
					begin
						state <= dts_pkg::ST_FORMAT;
						fmt_start <= 1'b1;
						fmt_cyl <= cmd_cdb[63:48];
						fmt_head <= cmd_cdb[47:40];
						fmt_use_hdr <= cmd_cdb[`DTS_HS_BIT];
						// Default header: supplied bytes never reach the formatter
						fmt_hdr_lba <= cmd_cdb[`DTS_HS_BIT] ? cmd_cdb[31:16] : 16'h0;
						fmt_hdr_flag <= cmd_cdb[`DTS_HS_BIT] ? cmd_cdb[15:8] : 8'h00;
					end
					else if (cmd_valid && op == `DTS_OP_RELEASE)
					begin
						status_valid <= 1'b1;
						status_code <= `DTS_ST_GOOD;
						cmd_ready <= 1'b1;
					end
					else if (cmd_valid && op == `DTS_OP_SENSE)
					begin
						state <= dts_pkg::ST_SEND;
						idx <= 5'h00;
					end
					else if (cmd_valid)
						cmd_ready <= 1'b1;
				end
				dts_pkg::ST_FORMAT:
				begin
					if (fmt_done)
					begin
						state <= dts_pkg::ST_IDLE;
						status_valid <= 1'b1;
						status_code <= `DTS_ST_GOOD;
						cmd_ready <= 1'b1;
					end
				end
				dts_pkg::ST_SEND:
				begin
					if (!sense_valid)
					begin
						sense_valid <= 1'b1;
						sense_byte <= mux_byte;
						sense_last <= xfer_len == 5'h01;
					end
					else if (sense_ready && sense_last)
					begin
						sense_valid <= 1'b0;
						sense_last <= 1'b0;
						state <= dts_pkg::ST_IDLE;
						status_valid <= 1'b1;
						status_code <= rs_fatal ? `DTS_ST_CHECK : `DTS_ST_GOOD;
						cmd_ready <= 1'b1;
					end
					else if (sense_ready)
					begin
						idx <= idx + 5'h01;
						sense_byte <= mux_byte;
						sense_last <= idx + 5'h02 == xfer_len;
					end
				end
				default: state <= dts_pkg::ST_IDLE;
			endcase
		end
	end

	always_comb
	begin
		ev = '0;
		ev[`DTS_EV_FMT] = state == dts_pkg::ST_FORMAT && fmt_done;
		ev[`DTS_EV_REL] = take && op == `DTS_OP_RELEASE;
		ev[`DTS_EV_SENSE] = rs_end;
		ev[`DTS_EV_CC] = cc_post;
	end

	// New events win over a write-one clear
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			irq_stat <= '0;
			irq_mask <= '0;
			single_init <= 1'b0;
			irq <= 1'b0;
		end
		else if (clk_en)
		begin
			if (reg_wr && reg_addr == `DTS_REG_CTRL)
				single_init <= reg_wdata[`DTS_CTRL_SINGLE];
			if (reg_wr && reg_addr == `DTS_REG_IRQ_MASK)
				irq_mask <= reg_wdata[`DTS_NUM_EV-1:0];
			if (reg_wr && reg_addr == `DTS_REG_IRQ_STAT)
				irq_stat <= (irq_stat & ~reg_wdata[`DTS_NUM_EV-1:0]) | ev;
			else
				irq_stat <= irq_stat | ev;
			irq <= |(irq_stat & irq_mask);
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			reg_rdata <= 32'h0;
		else if (clk_en)
		begin
			reg_rdata <= 32'h0;
			if (reg_rd)
			begin
				case (reg_addr)
					`DTS_REG_CTRL: reg_rdata <= {31'h0, single_init};
					`DTS_REG_IRQ_STAT: reg_rdata <= {{(32-`DTS_NUM_EV){1'b0}}, irq_stat};
					`DTS_REG_IRQ_MASK: reg_rdata <= {{(32-`DTS_NUM_EV){1'b0}}, irq_mask};
					`DTS_REG_STATE: reg_rdata <= {30'h0, state};
					`DTS_REG_SENSE_MAP: reg_rdata <= {{(32-NUM_LUN){1'b0}}, sense_map};
					`DTS_REG_RESV_MAP: reg_rdata <= {{(32-NUM_LUN){1'b0}}, resv_map};
					default: reg_rdata <= 32'h0;
				endcase
			end
		end
	end

	sequence s_fmt_cmd;
		take && op == `DTS_OP_REFORMAT;
	endsequence
	sequence s_sense_cmd;
		take && op == `DTS_OP_SENSE;
	endsequence

	property p_fmt_track;
		@(posedge clk_sys) disable iff (rst)
		s_fmt_cmd |=> fmt_start && fmt_cyl == $past(cmd_cdb[63:48]) && fmt_head == $past(cmd_cdb[47:40]);
	endproperty
	a_fmt_track: assert property (p_fmt_track) else $error("reformat track address wrong");
	property p_fmt_default;
		@(posedge clk_sys) disable iff (rst)
		s_fmt_cmd ##1 !fmt_use_hdr |-> fmt_hdr_lba == 16'h0 && fmt_hdr_flag == 8'h00;
	endproperty
	a_fmt_default: assert property (p_fmt_default) else $error("default header not used");
	property p_fmt_supplied;
		@(posedge clk_sys) disable iff (rst)
		s_fmt_cmd ##1 fmt_use_hdr |-> fmt_hdr_lba == $past(cmd_cdb[31:16]);
	endproperty
	a_fmt_supplied: assert property (p_fmt_supplied) else $error("supplied header lost");
	property p_release_good;
		@(posedge clk_sys) disable iff (rst)
		take && op == `DTS_OP_RELEASE |=> status_valid && status_code == `DTS_ST_GOOD;
	endproperty
	a_release_good: assert property (p_release_good) else $error("release not GOOD");
	property p_len_zero;
		@(posedge clk_sys) disable iff (rst)
		(s_sense_cmd and alloc == 8'h00) |=> xfer_len == 5'h04;
	endproperty
	a_len_zero: assert property (p_len_zero) else $error("zero allocation not four bytes");
	property p_len_cap;
		@(posedge clk_sys) disable iff (rst)
		state == dts_pkg::ST_SEND |-> xfer_len <= 5'h16 && idx < xfer_len;
	endproperty
	a_len_cap: assert property (p_len_cap) else $error("sense overrun");
	property p_byte0;
		@(posedge clk_sys) disable iff (rst)
		sense_valid && idx == 5'h00 && !$past(accept) |-> sense_byte[6:0] == 7'h70;
	endproperty
	a_byte0: assert property (p_byte0) else $error("sense byte 0 wrong");
	property p_byte2;
		@(posedge clk_sys) disable iff (rst)
		sense_valid && idx == 5'h02 |-> sense_byte[7:4] == 4'h0;
	endproperty
	a_byte2: assert property (p_byte2) else $error("sense byte 2 flags set");
	property p_byte7;
		@(posedge clk_sys) disable iff (rst)
		sense_valid && idx == 5'h07 |-> sense_byte == 8'h0E;
	endproperty
	a_byte7: assert property (p_byte7) else $error("additional length wrong");
	property p_other_clears;
		@(posedge clk_sys) disable iff (rst)
		clr_other && !cc_post |=> !sv[$past(lun)];
	endproperty
	a_other_clears: assert property (p_other_clears) else $error("sense kept after other command");
	property p_fatal_check;
		@(posedge clk_sys) disable iff (rst)
		clk_en && rs_end |=> status_valid && (status_code == `DTS_ST_CHECK) == $past(rs_fatal);
	endproperty
	a_fatal_check: assert property (p_fatal_check) else $error("sense status wrong");
endmodule // dts_cmd_core

// ==== test/dts_host_model.sv ====
// Initiator stand-in: hands command blocks to the block and sinks sense bytes.
// Assumes the bench calls issue() and reads rx_q, last_at and misses by path.
`timescale 1ns/1ps
module dts_host_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic stall,
	input wire logic cmd_ready,
	output logic cmd_valid,
	output logic [2:0] cmd_init,
	output logic [79:0] cmd_cdb,
	input wire logic sense_valid,
	input wire logic [7:0] sense_byte,
	input wire logic sense_last,
	output logic sense_ready
);
	logic [7:0] rx_q[$];
	int last_at = 0;
	int misses = 0;
	initial
	begin
		cmd_valid = 1'h0;
		cmd_init = 3'h0;
		cmd_cdb = 80'h0;
		sense_ready = 1'h0;
	end
	// A slow sink drops ready on random cycles
	always @(posedge clk_sys)
	begin
		sense_ready <= !rst && !stall;
		if (!rst && sense_valid === 1'h1 && sense_ready === 1'h1)
		begin
			rx_q.push_back(sense_byte);
			if (sense_last === 1'h1)
				last_at = rx_q.size();
		end
	end
	task automatic issue(input logic [2:0] ini, input logic [79:0] cdb);
		int n = 0;
		@(posedge clk_sys);
		while (cmd_ready !== 1'h1 && n < 500)
		begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 500)
			misses++;
		cmd_valid <= 1'h1;
		cmd_init <= ini;
		cmd_cdb <= cdb;
		@(posedge clk_sys);
		cmd_valid <= 1'h0;
		// Released lines carry junk, not the last command
		cmd_init <= ~ini;
		cmd_cdb <= ~cdb;
	endtask
endmodule // dts_host_model

// ==== test/tb_disk_track_release_sense_cmds.sv ====
// Self-checking bench for the reformat, release and sense request block.
// Assumes dts_defs.svh on the include path and the host model beside it.
`timescale 1ns/1ps
`include "dts_defs.svh"
module tb_disk_track_release_sense_cmds;
	logic clk_sys = 1'h0;
	logic rst = 1'h1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic cc_post = 1'h0;
	logic [2:0] cc_lun = 3'h0;
	logic [2:0] cc_init = 3'h0;
	logic [3:0] cc_key = 4'h0;
	logic [7:0] cc_asc = 8'h00;
	logic [31:0] cc_info = 32'h0;
	logic cc_info_ok = 1'h0;
	logic [31:0] cc_dev_err = 32'h0;
	logic resv_set = 1'h0;
	logic [2:0] resv_lun = 3'h0;
	logic [2:0] resv_init = 3'h0;
	logic resv_tp = 1'h0;
	logic [2:0] resv_tp_id = 3'h0;
	logic fmt_done = 1'h0;
	logic rs_fatal = 1'h0;
	logic cmd_valid, cmd_ready, sense_ready, sense_valid, sense_last, fmt_start, fmt_use_hdr, status_valid, irq, stall;
	logic [2:0] cmd_init;
	logic [79:0] cmd_cdb;
	logic [7:0] sense_byte, fmt_head, fmt_hdr_flag, status_code;
	logic [15:0] fmt_cyl, fmt_hdr_lba;
	logic [31:0] reg_rdata;
	logic [31:0] lf = 32'h957BBE01;
	logic [7:0] st_q[$];
	logic [31:0] mk[8], ma[8], mi[8], md[8];
	int mo[8];
	bit mv[8];
	logic [7:0] rsv = 8'h00;
	int r_ini[8], r_tp[8], r_id[8];
	bit slow = 1'h0;
	bit single = 1'h0;
	int err_total = 0;
	int tests_run = 0;
	assign stall = slow & lf[0];
	always #12.5 clk_sys = ~clk_sys;
	dts_cmd_core DUT (
		.clk_sys(clk_sys),
		.rst(rst),
		.clk_en(1'h1),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.cmd_valid(cmd_valid),
		.cmd_init(cmd_init),
		.cmd_cdb(cmd_cdb),
		.cmd_ready(cmd_ready),
		.cc_post(cc_post),
		.cc_lun(cc_lun),
		.cc_init(cc_init),
		.cc_key(cc_key),
		.cc_asc(cc_asc),
		.cc_info(cc_info),
		.cc_info_ok(cc_info_ok),
		.cc_dev_err(cc_dev_err),
		.resv_set(resv_set),
		.resv_lun(resv_lun),
		.resv_init(resv_init),
		.resv_tp(resv_tp),
		.resv_tp_id(resv_tp_id),
		.fmt_done(fmt_done),
		.rs_fatal(rs_fatal),
		.sense_ready(sense_ready),
		.fmt_start(fmt_start),
		.fmt_cyl(fmt_cyl),
		.fmt_head(fmt_head),
		.fmt_hdr_lba(fmt_hdr_lba),
		.fmt_hdr_flag(fmt_hdr_flag),
		.fmt_use_hdr(fmt_use_hdr),
		.sense_valid(sense_valid),
		.sense_byte(sense_byte),
		.sense_last(sense_last),
		.status_valid(status_valid),
		.status_code(status_code),
		.irq(irq)
	);
	dts_host_model host (
		.clk_sys(clk_sys),
		.rst(rst),
		.stall(stall),
		.cmd_ready(cmd_ready),
		.cmd_valid(cmd_valid),
		.cmd_init(cmd_init),
		.cmd_cdb(cmd_cdb),
		.sense_valid(sense_valid),
		.sense_byte(sense_byte),
		.sense_last(sense_last),
		.sense_ready(sense_ready)
	);
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	always @(posedge clk_sys)
	begin
		lf <= lfsr(lf);
		if (status_valid === 1'h1)
			st_q.push_back(status_code);
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		err_total += host.misses;
		$display("comparisons %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic done(input string s);
		$display("test %s finished at %0t", s, $time);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'h0;
		#1 cmp(reg_rdata, exp);
	endtask
	task automatic chk_status(input logic [7:0] exp);
		int n = 0;
		while (st_q.size() == 0 && n < 400)
		begin
			@(posedge clk_sys);
			n++;
		end
		cmp(st_q.size(), 1);
		if (st_q.size() > 0)
			cmp(st_q.pop_front(), exp);
	endtask
	task automatic st(int l, int o, logic [31:0] k, logic [31:0] a, logic [31:0] i, bit v, logic [31:0] d);
		mo[l] = o;
		mk[l] = k;
		ma[l] = a;
		mi[l] = i;
		mv[l] = v;
		md[l] = d;
	endtask
	// Owner -1 means any initiator may fetch or clear it
	task automatic clr(int l, int ini);
		if (mo[l] < 0 || mo[l] == ini)
			st(l, -1, 0, 0, 0, 0, 0);
	endtask
	task automatic post(int l, int ini, logic [3:0] k, logic [7:0] a, bit v);
		logic [31:0] r;
		@(posedge clk_sys);
		r = lf;
		cc_post <= 1'h1;
		cc_lun <= l[2:0];
		cc_init <= ini[2:0];
		cc_key <= k;
		cc_asc <= a;
		cc_info <= r;
		cc_info_ok <= v;
		cc_dev_err <= ~r;
		@(posedge clk_sys);
		cc_post <= 1'h0;
		st(l, ini, k, a, r, v, ~r);
	endtask
	task automatic sense(int ini, int l, int alloc, bit fatal);
		logic [7:0] e[22];
		int who, n;
		who = (single && mo[l] >= 0) ? mo[l] : ini;
		n = alloc == 0 ? 4 : (alloc < 22 ? alloc : 22);
		for (int i = 0; i < 22; i++)
			e[i] = 8'h00;
		e[0] = 8'h70;
		e[7] = `DTS_ADD_LEN;
		if (mo[l] < 0 || mo[l] == who)
		begin
			e[0][7] = mv[l];
			e[2] = mk[l][7:0];
			{e[3], e[4], e[5], e[6]} = mi[l];
			e[12] = ma[l][7:0];
			{e[18], e[19], e[20], e[21]} = md[l];
			if (!fatal)
				st(l, -1, 0, 0, 0, 0, 0);
		end
		host.rx_q.delete();
		host.last_at = 0;
		rs_fatal <= fatal;
		host.issue(ini[2:0], {8'h03, l[2:0], 5'h00, 16'h0, alloc[7:0], 40'h0});
		chk_status(fatal ? `DTS_ST_CHECK : `DTS_ST_GOOD);
		rs_fatal <= 1'h0;
		cmp(host.rx_q.size(), n);
		cmp(host.last_at, n);
		for (int i = 0; i < n && i < host.rx_q.size(); i++)
			cmp(host.rx_q[i], e[i]);
	endtask
	task automatic resv(int l, int ini, bit tp, int id);
		@(posedge clk_sys);
		resv_set <= 1'h1;
		resv_lun <= l[2:0];
		resv_init <= ini[2:0];
		resv_tp <= tp;
		resv_tp_id <= id[2:0];
		@(posedge clk_sys);
		resv_set <= 1'h0;
		rsv[l] = 1'h1;
		r_ini[l] = ini;
		r_tp[l] = tp;
		r_id[l] = id;
	endtask
	task automatic do_release(int ini, int l, bit tp, int id);
		host.issue(ini[2:0], {8'h17, l[2:0], tp, id[2:0], 1'h0, 64'h0});
		chk_status(`DTS_ST_GOOD);
		if (rsv[l] && r_ini[l] == ini && r_tp[l] == tp && (!tp || r_id[l] == id))
			rsv[l] = 1'h0;
		clr(l, ini);
		rd(`DTS_REG_RESV_MAP, {24'h0, rsv});
	endtask
	task automatic reformat(int ini, int l, bit hs);
		logic [31:0] v;
		int n = 0;
		v = lf;
		host.issue(ini[2:0], {8'hED, l[2:0], 4'h0, hs, v, ~v[31:8], 8'h00});
		while (fmt_start !== 1'h1 && n < 100)
		begin
			@(posedge clk_sys);
			n++;
		end
		cmp({fmt_cyl, fmt_head}, v[31:8]);
		cmp({fmt_use_hdr, fmt_hdr_lba, fmt_hdr_flag}, hs ? {1'h1, ~v[31:8]} : 25'h0);
		fmt_done <= 1'h1;
		@(posedge clk_sys);
		fmt_done <= 1'h0;
		chk_status(`DTS_ST_GOOD);
		clr(l, ini);
	endtask
	initial
	begin
		for (int l = 0; l < 8; l++)
			st(l, -1, `DTS_KEY_UA, `DTS_ASC_RESET, 0, 0, 0);
		repeat (4) @(posedge clk_sys);
		rst <= 1'h0;
		rd(`DTS_REG_CTRL, 32'h0);
		rd(`DTS_REG_SENSE_MAP, 32'hFF);
		wr(8'h40, 32'hFFFFFFFF);
		rd(8'h40, 32'h0);
		rd(`DTS_REG_CTRL, 32'h0);
		rd(`DTS_REG_STATE, 32'h0);
		done("registers");
		sense(0, 0, 0, 0);
		sense(0, 0, 0, 0);
		slow = 1'h1;
		post(1, 2, 4'h3, 8'h11, 1'h1);
		sense(2, 1, 255, 0);
		slow = 1'h0;
		post(2, 1, 4'h5, 8'h24, 1'h0);
		sense(1, 2, 22, 1);
		sense(1, 2, 23, 0);
		done("sense data");
		post(3, 1, 4'h3, 8'h11, 1'h1);
		sense(4, 3, 18, 0);
		do_release(1, 3, 0, 0);
		sense(1, 3, 18, 0);
		// Unknown opcode from the owner: no status, but the sense must go
		post(0, 3, 4'h5, 8'h20, 1'h0);
		host.issue(3'h3, {8'h00, 3'h0, 69'h0});
		clr(0, 3);
		sense(3, 0, 0, 0);
		wr(`DTS_REG_CTRL, 32'h1);
		single = 1'h1;
		post(4, 5, 4'h6, 8'h29, 1'h0);
		sense(2, 4, 5, 0);
		wr(`DTS_REG_CTRL, 32'h0);
		single = 1'h0;
		done("preservation");
		resv(5, 3, 1'h1, 6);
		sense(0, 5, 8, 0);
		do_release(3, 5, 0, 0);
		do_release(3, 5, 1, 2);
		do_release(3, 5, 1, 6);
		done("release");
		reformat(1, 6, 0);
		reformat(1, 6, 1);
		done("reformat");
		wr(`DTS_REG_IRQ_STAT, 32'hF);
		wr(`DTS_REG_IRQ_MASK, 32'h2);
		do_release(0, 7, 0, 0);
		cmp(irq, 1'h1);
		rd(`DTS_REG_IRQ_STAT, 32'h2);
		wr(`DTS_REG_IRQ_STAT, 32'h2);
		repeat (2) @(posedge clk_sys);
		#1 cmp(irq, 1'h0);
		wr(`DTS_REG_IRQ_MASK, 32'h0);
		do_release(0, 7, 0, 0);
		cmp(irq, 1'h0);
		done("interrupt");
		stop_test;
	end
	// Whole run is a few hundred cycles; this margin only catches hangs
	initial
	begin
		#(25 * 20000);
		err_total++;
		stop_test;
	end
endmodule // tb_disk_track_release_sense_cmds
